//--- verilog/bcr_bank.sv
// Purpose: driver-stage bias register bank with fuse load and unlock key
// Assumes: one write or read request per cycle; all inputs except the asynchronous reset RSTN_I synchronous
// Notes: read data registered one cycle after the read strobe
// How it works
// R1: writing soft reset restores DAC and privileged-mode defaults; control bits keep the written value
// R2: fuse refresh reloads DAC registers from fuses
// R3: host clears refresh bit after refresh completes
// R4: bits 0-3 hold fixed read-only revision
// R5: control bits read zero after reset
// R6: sense reference six bits, default 0x20
// R7: carrier gate eight bits, default 0x80
// R8: peaking gate eight bits, default 0x80
// R9: code 0x00 gives ceiling gate voltage
// R10: reset copies fuse values into DAC registers
// R11: fallback defaults only when fuses unprogrammed
// R12: DAC writes only accepted while privileged
// R13: key 0xE3 enters privileged mode, else leaves
// R14: unavailable bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
module bcr_bank
  import bcr_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [4:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire bcr_dac_t FUSE_I,
  input wire logic FUSE_PROG_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  output bcr_dac_t DAC_O,
  output logic PRIV_O
);
  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  logic [7:0] sys_q;
  logic [7:0] sys_d;
  bcr_dac_t dac_q;
  bcr_dac_t dac_d;
  logic priv_q;
  logic priv_d;
  bcr_load_t load_q;
  bcr_load_t load_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic soft_reset_q;
  wire wr_sys = WR_I && (ADDR_I == ADDR_SYS_CTRL);
  wire wr_key = WR_I && (ADDR_I == ADDR_UNLOCK_KEY);
  wire wr_dac_ok = WR_I && priv_q; // R12
  wire wr_sense = wr_dac_ok && (ADDR_I == ADDR_SENSE_REF);
  wire wr_carrier = wr_dac_ok && (ADDR_I == ADDR_CARRIER_GATE);
  wire wr_peaking = wr_dac_ok && (ADDR_I == ADDR_PEAKING_GATE);
  wire soft_reset_set = wr_sys && WDATA_I[SOFT_RESET_BIT]; // R1
  wire refresh_set = wr_sys && WDATA_I[FUSE_REFRESH_BIT]; // R2
  // fuse image or fallback defaults
  wire bcr_dac_t fuse_image = FUSE_PROG_I ? FUSE_I :
    bcr_dac_t'{SENSE_DEFAULT, CARRIER_DEFAULT, PEAKING_DEFAULT}; // R11
  wire bcr_dac_t fuse_masked = bcr_dac_t'{fuse_image.sense & SENSE_MASK,
    fuse_image.carrier, fuse_image.peaking}; // R14
  wire [7:0] sys_view = {1'b0, sys_q[6:5], 1'b0, CHIP_REVISION}; // R4 R14
  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    sys_d = sys_q;
    dac_d = dac_q;
    priv_d = priv_q;
    load_d = LOAD_IDLE;
    if (wr_sys)
    begin
      sys_d = WDATA_I & SYS_CTRL_WMASK; // R3 R5
    end
    if (wr_key)
    begin
      priv_d = (WDATA_I == UNLOCK_KEY); // R13
    end
    if (wr_sense)
    begin
      dac_d.sense = WDATA_I & SENSE_MASK; // R6 R14
    end
    if (wr_carrier)
    begin
      dac_d.carrier = WDATA_I; // R7 R9
    end
    if (wr_peaking)
    begin
      dac_d.peaking = WDATA_I; // R8 R9
    end
    case (load_q)
      LOAD_FUSE:
      begin
        dac_d = fuse_masked; // R10
      end
      LOAD_IDLE:
      begin
      end
      default:
      begin
      end
    endcase
    if (refresh_set)
    begin
      load_d = LOAD_FUSE; // R2
    end
    if (soft_reset_set)
    begin
      // DAC and privileged mode back to defaults, control bits kept as written
      priv_d = 1'b0;
      load_d = LOAD_FUSE; // R1 R10
    end
  end

  // --------------------------------------------------------------
  // read selection
  // --------------------------------------------------------------
  wire rd_sys = (ADDR_I == ADDR_SYS_CTRL);
  wire rd_sense = (ADDR_I == ADDR_SENSE_REF);
  wire rd_carrier = (ADDR_I == ADDR_CARRIER_GATE);
  wire rd_peaking = (ADDR_I == ADDR_PEAKING_GATE);
  // unmapped and write-only addresses read zero
  assign rdata_d = ({8{rd_sys}} & sys_view)
    | ({8{rd_sense}} & dac_q.sense)
    | ({8{rd_carrier}} & dac_q.carrier)
    | ({8{rd_peaking}} & dac_q.peaking); // R12
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sys_q <= 8'h00; // R5
      dac_q <= '0;
      priv_q <= 1'b0;
      load_q <= LOAD_FUSE; // R10
      soft_reset_q <= 1'b0;
    end
    else
    begin
      sys_q <= sys_d;
      dac_q <= dac_d;
      priv_q <= priv_d;
      load_q <= load_d;
      soft_reset_q <= soft_reset_set;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= RD_I ? rdata_d : rdata_q;
      rvalid_q <= RD_I;
    end
  end

  assign RDATA_O = rdata_q;
  assign RVALID_O = rvalid_q;
  assign DAC_O = dac_q;
  assign PRIV_O = priv_q;
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_refresh_loads_fuse: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R2
    refresh_set |=> ##1 (dac_q == fuse_masked))
    else $error("refresh did not load fuse image");
  a_locked_write_dropped: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R12
    (WR_I && !priv_q && load_q == LOAD_IDLE && !refresh_set && !soft_reset_set)
    |=> $stable(dac_q))
    else $error("DAC changed while locked");
  a_key_enters_priv: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R13
    (wr_key && WDATA_I == UNLOCK_KEY && !soft_reset_set) |=> priv_q)
    else $error("unlock key ignored");
  a_other_key_leaves: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R13
    (wr_key && WDATA_I != UNLOCK_KEY) |=> !priv_q)
    else $error("wrong key kept privileged mode");
  a_revision_fixed: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R4
    RD_I && ADDR_I == ADDR_SYS_CTRL |=> RDATA_O[3:0] == CHIP_REVISION)
    else $error("revision field altered");
  a_reserved_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R14
    RD_I && (ADDR_I == ADDR_SYS_CTRL || ADDR_I == ADDR_SENSE_REF)
    |=> (RDATA_O[7] == 1'b0)
    && ($past(ADDR_I) != ADDR_SYS_CTRL || RDATA_O[4] == 1'b0)
    && ($past(ADDR_I) != ADDR_SENSE_REF || RDATA_O[6] == 1'b0))
    else $error("reserved bit read as one");
  a_sense_six_bits: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R6
    dac_q.sense[7:6] == 2'b00)
    else $error("sense register upper bits set");
  a_soft_reset_reload: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R1
    soft_reset_set |=> !priv_q ##1 (dac_q == fuse_masked))
    else $error("soft reset did not restore defaults");
  a_carrier_write: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R7
    (wr_carrier && load_q == LOAD_IDLE && !refresh_set && !soft_reset_set)
    |=> dac_q.carrier == $past(WDATA_I))
    else $error("carrier gate write lost");
  c_unlock_write: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    priv_q && wr_peaking);
  c_refresh: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) refresh_set);
  c_soft_reset: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) soft_reset_q);

  // --------------------------------------------------------------
  // assertions: reset and fuse load
  // --------------------------------------------------------------
  a_reset_clears_ctrl: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R5
    $rose(RSTN_I) |-> (sys_q == 8'h00) && !priv_q)
    else $error("control bits set after reset");

  a_reset_starts_load: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R10
    $rose(RSTN_I) |-> (load_q == LOAD_FUSE))
    else $error("no fuse load pending after reset");

  a_refresh_sets_load: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R2
    refresh_set |=> (load_q == LOAD_FUSE))
    else $error("refresh did not request a fuse load");

  // load wins over a same-cycle DAC write
  a_load_applies_fuse: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R10
    (load_q == LOAD_FUSE) |=> (dac_q == $past(fuse_masked)))
    else $error("fuse load not applied");

  a_fallback_defaults: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R11
    (load_q == LOAD_FUSE) && !FUSE_PROG_I
    |=> (dac_q == bcr_dac_t'{SENSE_DEFAULT, CARRIER_DEFAULT, PEAKING_DEFAULT}))
    else $error("fallback defaults not loaded");

  a_fuse_precedence: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R11
    (load_q == LOAD_FUSE) && FUSE_PROG_I
    |=> (dac_q.carrier == $past(FUSE_I.carrier))
    && (dac_q.peaking == $past(FUSE_I.peaking)))
    else $error("programmed fuses lost to defaults");

  // --------------------------------------------------------------
  // assertions: register writes
  // --------------------------------------------------------------
  a_sys_write_mask: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R14
    wr_sys |=> (sys_q == ($past(WDATA_I) & SYS_CTRL_WMASK)))
    else $error("control register write mask wrong");

  a_sys_unused_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R14
    (sys_q & ~SYS_CTRL_WMASK) == 8'h00)
    else $error("unused control bits stored");

  a_soft_reset_kept: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R1
    soft_reset_set |=> sys_q[SOFT_RESET_BIT])
    else $error("soft reset bit not held for host");

  a_sense_write: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R6
    (wr_sense && load_q == LOAD_IDLE)
    |=> (dac_q.sense == ($past(WDATA_I) & SENSE_MASK)))
    else $error("sense reference write lost");

  a_peaking_write: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R8
    (wr_peaking && load_q == LOAD_IDLE)
    |=> (dac_q.peaking == $past(WDATA_I)))
    else $error("peaking gate write lost");

  a_gate_code_verbatim: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R9
    (wr_carrier && load_q == LOAD_IDLE && WDATA_I == 8'h00)
    |=> (DAC_O.carrier == 8'h00))
    else $error("ceiling code not passed to carrier gate");

  a_priv_key_only: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R13
    (!wr_key && !soft_reset_set) |=> $stable(priv_q))
    else $error("privileged mode changed without key");

  // --------------------------------------------------------------
  // assertions: reads
  // --------------------------------------------------------------
  a_read_answers: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R12
    RD_I |=> RVALID_O)
    else $error("read not answered");

  a_read_idle_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R12
    !RD_I |=> !RVALID_O && $stable(RDATA_O))
    else $error("read answer without request");

  a_dac_read_back: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R12
    (RD_I && ADDR_I == ADDR_CARRIER_GATE)
    |=> (RDATA_O == $past(dac_q.carrier)))
    else $error("carrier gate read back wrong");

  a_key_not_readable: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // R13
    (RD_I && ADDR_I == ADDR_UNLOCK_KEY) |=> (RDATA_O == 8'h00))
    else $error("unlock key readable");

  // --------------------------------------------------------------
  // covers
  // --------------------------------------------------------------
  c_locked_drop: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    WR_I && !priv_q && (ADDR_I == ADDR_CARRIER_GATE));
  c_key_leave: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    wr_key && (WDATA_I != UNLOCK_KEY));
endmodule // bcr_bank
`default_nettype wire

//--- verilog/bcr_pkg.sv
// Purpose: shared constants and types for the bias control register bank
// Assumes: 8-bit registers reached by a parallel register port
// Notes: fuse storage contents arrive on plain inputs
`default_nettype none
package bcr_pkg;
  // --------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------
  localparam logic [4:0] ADDR_SYS_CTRL = 5'h00;
  localparam logic [4:0] ADDR_SENSE_REF = 5'h01;
  localparam logic [4:0] ADDR_CARRIER_GATE = 5'h02;
  localparam logic [4:0] ADDR_PEAKING_GATE = 5'h03;
  localparam logic [4:0] ADDR_UNLOCK_KEY = 5'h11;
  // --------------------------------------------------------------
  // field positions and values
  // --------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 6;
  localparam int FUSE_REFRESH_BIT = 5;
  localparam logic [7:0] SENSE_MASK = 8'h3f;
  localparam logic [7:0] SYS_CTRL_WMASK = 8'h60;
  localparam logic [7:0] SENSE_DEFAULT = 8'h20;
  localparam logic [7:0] CARRIER_DEFAULT = 8'h80;
  localparam logic [7:0] PEAKING_DEFAULT = 8'h80;
  localparam logic [7:0] UNLOCK_KEY = 8'he3;
  // arbitrary revision value
  localparam logic [3:0] CHIP_REVISION = 4'h1;

  typedef struct packed {
    logic [7:0] sense;
    logic [7:0] carrier;
    logic [7:0] peaking;
  } bcr_dac_t;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_FUSE
  } bcr_load_t;
endpackage
`default_nettype wire

//--- testbench/bcr_host.sv
// Purpose: host controller model on the register port
// Assumes: requests launched just after a rising edge
// Notes: released write data shows inverted last value
`timescale 1ns/100ps
`default_nettype none
module bcr_host (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 3)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
endmodule // bcr_host
`default_nettype wire

//--- testbench/tb_bias_control_register_bank.sv
// Purpose: self-checking bench for the bias register bank
// Assumes: outputs settle within 1 ns of an edge
// Notes: fuse image differs from fallback defaults
`timescale 1ns/100ps
`default_nettype none
module tb_bias_control_register_bank;
  import bcr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fprog = 1'b0;
  bcr_dac_t fuse = 24'hc5_3c_a7;
  bcr_dac_t dac;
  logic [4:0] addr;
  logic wr, rd, rvalid, priv;
  logic [7:0] wdata, rdata, rev;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  assign rev = {4'h0, CHIP_REVISION};
  bcr_bank bcr_bank_inst (.CLK_SYS_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WR_I(wr),
    .RD_I(rd), .WDATA_I(wdata), .FUSE_I(fuse), .FUSE_PROG_I(fprog), .RDATA_O(rdata),
    .RVALID_O(rvalid), .DAC_O(dac), .PRIV_O(priv));
  bcr_host bcr_host_inst (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    bcr_host_inst.rd(a, d);
    chk({16'h0, d}, {16'h0, e});
  endtask
  task automatic t_boot;
    chk(dac, {SENSE_DEFAULT, CARRIER_DEFAULT, PEAKING_DEFAULT});
    rchk(ADDR_SYS_CTRL, rev);
  endtask
  task automatic t_lock;
    bcr_host_inst.wr(ADDR_CARRIER_GATE, 8'h11);
    chk(dac, {SENSE_DEFAULT, CARRIER_DEFAULT, PEAKING_DEFAULT});
    bcr_host_inst.wr(ADDR_UNLOCK_KEY, UNLOCK_KEY);
    chk(priv, 1'b1);
    bcr_host_inst.wr(ADDR_SENSE_REF, 8'hff);
    bcr_host_inst.wr(ADDR_CARRIER_GATE, 8'h00);
    bcr_host_inst.wr(ADDR_PEAKING_GATE, 8'hff);
    chk(dac, 24'h3f_00_ff);
    rchk(ADDR_SENSE_REF, 8'h3f);
    rchk(ADDR_PEAKING_GATE, 8'hff);
    bcr_host_inst.wr(ADDR_UNLOCK_KEY, 8'he2);
    chk(priv, 1'b0);
    bcr_host_inst.wr(ADDR_PEAKING_GATE, 8'h55);
    chk(dac.peaking, 8'hff);
  endtask
  task automatic t_refresh;
    @(posedge clk);
    fprog <= 1'b1;
    bcr_host_inst.wr(ADDR_SYS_CTRL, 8'h20);
    @(posedge clk);
    #1;
    chk(dac, 24'h05_3c_a7);
    rchk(ADDR_SYS_CTRL, 8'h20 | rev);
    bcr_host_inst.wr(ADDR_SYS_CTRL, 8'h00);
  endtask
  task automatic t_soft;
    bcr_host_inst.wr(ADDR_UNLOCK_KEY, UNLOCK_KEY);
    bcr_host_inst.wr(ADDR_CARRIER_GATE, 8'h12);
    bcr_host_inst.wr(ADDR_SYS_CTRL, 8'hdf);
    @(posedge clk);
    #1;
    chk(priv, 1'b0);
    chk(dac, 24'h05_3c_a7);
    rchk(ADDR_SYS_CTRL, 8'h40 | rev);
    bcr_host_inst.wr(ADDR_SYS_CTRL, 8'h00);
    rchk(ADDR_SYS_CTRL, rev);
  endtask
  task automatic t_rerun;
    bcr_host_inst.wr(ADDR_UNLOCK_KEY, UNLOCK_KEY);
    bcr_host_inst.wr(ADDR_SYS_CTRL, 8'h20);
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    chk(dac, 24'h00_00_00);
    chk({rvalid, priv, rdata}, 24'h00_00_00);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(dac, 24'h05_3c_a7);
    chk(priv, 1'b0);
    rchk(ADDR_SYS_CTRL, rev);
    bcr_host_inst.wr(ADDR_CARRIER_GATE, 8'h33);
    chk(dac.carrier, 8'h3c);
  endtask
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_boot();
    t_lock();
    t_refresh();
    t_soft();
    t_rerun();
    close_out();
  end
endmodule // tb_bias_control_register_bank
`default_nettype wire
